// *** rtl/cie_pkg.sv ***
package cie_pkg;
	// system clock and the device clock made from it
	localparam int CLOCK_PERIOD_NS = 8;
	localparam int DEV_CLOCK_PERIOD_NS = 160;
	localparam int DEV_CLOCK_HALF_CYC = DEV_CLOCK_PERIOD_NS / (2 * CLOCK_PERIOD_NS);
	localparam int DIV_CNT_W = 5;
	// wait for input done after the terminator has gone out
	localparam int DONE_WAIT_MS = 100;
	localparam int DONE_WAIT_CYC = DONE_WAIT_MS * 1000000 / CLOCK_PERIOD_NS;
	localparam int WAIT_CNT_W = 24;
	// character framing: six data bits, odd parity on top, lsb first
	localparam int CHAR_W = 6;
	localparam int FRAME_W = 7;
	localparam int BIT_CNT_W = 3;
	localparam int PAGE_LSB = 4;
	localparam logic [5:0] MESSAGE_TERMINATOR = 6'h0f;
	localparam logic [5:0] ZERO_CHAR = 6'h00;
	// message type codes in the low nibble of a control character
	localparam logic [3:0] CTRL_KEY_TYPE = 4'hf;
	localparam logic [3:0] LOGIC_KEY_TYPE = 4'h9;
	// character slot numbers within one message
	localparam logic [1:0] SLOT_HEAD = 2'h0;
	localparam logic [1:0] SLOT_SECOND = 2'h1;
	localparam logic [1:0] SLOT_LAST = 2'h3;

	typedef enum {ST_IDLE, ST_REQUEST, ST_SEND, ST_WAIT_DONE, ST_ERROR} cie_state_e;
	typedef enum {KIND_TEXT, KIND_CTRL} cie_kind_e;

	// odd parity frame of one character
	function automatic logic [FRAME_W-1:0] cie_frame(input logic [CHAR_W-1:0] d);
		return {~^d, d};
	endfunction
endpackage

// *** rtl/cie_ser_if.sv ***
`timescale 1ns/1ps
interface cie_ser_if;
	import cie_pkg::*;
	logic load; // one-cycle order to send chr
	logic [FRAME_W-1:0] chr; // framed character
	logic busy; // char pending or on the line
	logic active; // bits on the line, clock may run
	logic done; // last bit of a char finished
	logic bit_out; // current serial bit
	logic rise; // device clock rising enable
	logic fall; // device clock falling enable
	logic clk_level; // free-running device clock level
	modport top (output load, chr, input busy, active, done, bit_out, rise, fall, clk_level);
	modport ser (input load, chr, fall, output busy, active, done, bit_out);
	modport div (output rise, fall, clk_level);
endinterface

// *** rtl/cie_clkdiv.sv ***
`timescale 1ns/1ps
module cie_clkdiv import cie_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// device clock phase and edge enables
	cie_ser_if.div sif
);
	logic [DIV_CNT_W-1:0] cnt; // cycles within a half period

	// half-period counter, toggles the level and pulses the edge enables
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
			sif.clk_level <= 1'b0;
			sif.rise <= 1'b0;
			sif.fall <= 1'b0;
		end else if (cnt == DIV_CNT_W'(DEV_CLOCK_HALF_CYC - 1)) begin
			cnt <= '0;
			sif.clk_level <= ~sif.clk_level;
			sif.rise <= ~sif.clk_level;
			sif.fall <= sif.clk_level;
		end else begin
			cnt <= cnt + DIV_CNT_W'(1);
			sif.rise <= 1'b0;
			sif.fall <= 1'b0;
		end
	end
endmodule

// *** rtl/cie_serializer.sv ***
`timescale 1ns/1ps
module cie_serializer import cie_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// character in, serial bit out
	cie_ser_if.ser sif
);
	logic [FRAME_W-1:0] shreg; // bits still to go, lsb on the line
	logic [BIT_CNT_W-1:0] cnt; // bits already shifted
	logic pend; // loaded, waiting for a falling edge
	logic last; // final bit is on the line

	assign last = sif.active && (cnt == BIT_CNT_W'(FRAME_W - 1));
	assign sif.busy = pend | sif.active;
	assign sif.bit_out = shreg[0];

	// pending flag, starts a char only at a falling edge so no clock sliver
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend <= 1'b0;
		end else if (sif.load) begin
			pend <= 1'b1;
		end else if (sif.fall && !sif.active) begin
			pend <= 1'b0;
		end
	end

	// shifter: data changes only on falling edges, held while clock high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shreg <= '0;
			cnt <= '0;
			sif.active <= 1'b0;
			sif.done <= 1'b0;
		end else begin
			sif.done <= 1'b0;
			if (sif.load) begin
				shreg <= sif.chr;
			end else if (sif.fall && sif.active) begin
				if (last) begin
					sif.active <= 1'b0;
					sif.done <= 1'b1;
				end else begin
					shreg <= {1'b0, shreg[FRAME_W-1:1]};
					cnt <= cnt + BIT_CNT_W'(1);
				end
			end else if (sif.fall && pend) begin
				sif.active <= 1'b1;
				cnt <= '0;
			end
		end
	end

	a_nrz_bit_hold: assert property (@(posedge clk) disable iff (rst)
		sif.active && !sif.fall && !sif.load |=> $stable(sif.bit_out))
		else $error("serial bit moved away from a falling edge");
endmodule

// *** rtl/cie_console.sv ***
`timescale 1ns/1ps
module cie_console import cie_pkg::*; #(
	parameter int DONE_WAIT_CYCLES = DONE_WAIT_CYC // wait for input done
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// lines from the processor
	input wire logic TRANSFER_ACTIVE_LINE,
	input wire logic INPUT_DONE_LINE,
	input wire logic SEND_REQUEST_LINE,
	// lines to the processor
	output logic AVAILABLE_LINE,
	output logic DEVICE_CLOCK,
	output logic INPUT_DATA,
	// operator keys
	input wire logic MSG_KEY,
	input wire logic [3:0] MSG_CODE,
	input wire logic FUNC_KEY,
	input wire logic [CHAR_W-1:0] FUNC_CODE,
	input wire logic LOGIC_KEY,
	input wire logic [CHAR_W-1:0] LOGIC_CODE,
	input wire logic [1:0] TEXT_DISPLAY_PAGE,
	input wire logic [CHAR_W-1:0] OVERLAY_CODE,
	// console control
	input wire logic STANDBY,
	input wire logic ENABLE_KEYS,
	input wire logic OUTBOUND_FAULT,
	input wire logic LAMP_CLEAR,
	// text stream from the display
	input wire logic TEXT_VALID,
	input wire logic [FRAME_W-1:0] TEXT_CHAR,
	input wire logic TEXT_LAST,
	output logic TEXT_READY,
	// operator indications
	output logic KEYS_ENABLED,
	output logic INBOUND_FAULT_LAMP,
	output logic OUTBOUND_FAULT_LAMP,
	output logic BUSY
);
	localparam logic [WAIT_CNT_W-1:0] WAIT_LAST = WAIT_CNT_W'(DONE_WAIT_CYCLES - 1);

	cie_ser_if sif ();
	cie_state_e state; // transfer sequencer
	cie_kind_e kind; // text or control message
	logic [2:0] pin_m, pin_s; // pin synchroniser stages
	logic ta, idone, sreq; // synchronised processor lines
	logic [CHAR_W-1:0] hdr, c1, c2; // assembled message characters
	logic [CHAR_W-1:0] next_char; // next fixed char to frame
	logic [1:0] idx; // next character slot
	logic tail; // terminator has been loaded
	logic keys_en; // key lock released
	logic keys_usable; // keys may start a transfer now
	logic [WAIT_CNT_W-1:0] wait_cnt; // done and error wait timer
	logic start_ok, grant, text_take, par_fault, line_fault, done_tmo, err_evt, ok_evt, free;

	// device clock divider and character shifter
	cie_clkdiv u_div (
		.clk(CLOCK),
		.rst(RST),
		.sif(sif.div)
	);
	cie_serializer u_ser (
		.clk(CLOCK),
		.rst(RST),
		.sif(sif.ser)
	);

	// two-stage synchroniser for the processor lines
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			pin_m <= '0;
			pin_s <= '0;
		end else begin
			pin_m <= {TRANSFER_ACTIVE_LINE, INPUT_DONE_LINE, SEND_REQUEST_LINE};
			pin_s <= pin_m;
		end
	end
	assign ta = pin_s[2];
	assign idone = pin_s[1];
	assign sreq = pin_s[0];

	// events of the current cycle
	assign keys_usable = keys_en && !sreq && !STANDBY;
	assign start_ok = (state == ST_IDLE) && keys_usable && (MSG_KEY || FUNC_KEY || LOGIC_KEY);
	assign grant = (state == ST_REQUEST) && ta && !sreq;
	assign text_take = TEXT_READY && TEXT_VALID;
	assign par_fault = text_take && !(^TEXT_CHAR);
	// line dropped or done too early is a processor-side error
	assign line_fault = ((state == ST_SEND) && (!ta || idone))
		|| ((state == ST_WAIT_DONE) && !ta && !idone);
	assign done_tmo = (state == ST_WAIT_DONE) && !idone && (wait_cnt == WAIT_LAST);
	assign err_evt = line_fault || par_fault || done_tmo;
	assign ok_evt = (state == ST_WAIT_DONE) && idone;
	assign free = !sif.busy && !sif.load;

	// transfer sequencer with the availability line
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state <= ST_IDLE;
			AVAILABLE_LINE <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_ok) begin
						state <= ST_REQUEST;
						AVAILABLE_LINE <= 1'b1;
					end
				end
				ST_REQUEST: begin
					if (grant) begin
						state <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (err_evt) begin
						state <= ST_ERROR;
						AVAILABLE_LINE <= 1'b0;
					end else if (sif.done && tail) begin
						state <= ST_WAIT_DONE;
					end
				end
				ST_WAIT_DONE: begin
					if (ok_evt) begin
						state <= ST_IDLE;
						AVAILABLE_LINE <= 1'b0;
					end else if (err_evt) begin
						state <= ST_ERROR;
						AVAILABLE_LINE <= 1'b0;
					end
				end
				ST_ERROR: begin
					// let the char finish, then wait for the processor to let go
					if (!sif.busy && (!ta || wait_cnt == WAIT_LAST)) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
					AVAILABLE_LINE <= 1'b0;
				end
			endcase
		end
	end

	// wait timer, restarted on entry to waiting or error
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			wait_cnt <= '0;
		end else if (err_evt || (sif.done && tail)) begin
			wait_cnt <= '0;
		end else if ((state == ST_WAIT_DONE || state == ST_ERROR) && wait_cnt != WAIT_LAST) begin
			wait_cnt <= wait_cnt + WAIT_CNT_W'(1);
		end
	end

	// message assembly from the key pressed, message key first
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			kind <= KIND_TEXT;
			hdr <= '0;
			c1 <= '0;
			c2 <= '0;
		end else if (start_ok) begin
			if (MSG_KEY) begin
				kind <= KIND_TEXT;
				hdr <= {TEXT_DISPLAY_PAGE, MSG_CODE};
				c1 <= ZERO_CHAR;
				c2 <= ZERO_CHAR;
			end else if (FUNC_KEY) begin
				kind <= KIND_CTRL;
				hdr <= {TEXT_DISPLAY_PAGE, CTRL_KEY_TYPE};
				c1 <= ZERO_CHAR;
				c2 <= FUNC_CODE;
			end else begin
				kind <= KIND_CTRL;
				hdr <= {TEXT_DISPLAY_PAGE, LOGIC_KEY_TYPE};
				c1 <= OVERLAY_CODE;
				c2 <= LOGIC_CODE;
			end
		end
	end

	// fixed character of the current slot
	always_comb begin
		case (idx)
			SLOT_HEAD: next_char = hdr;
			SLOT_SECOND: next_char = c1;
			2'h2: next_char = c2;
			default: next_char = MESSAGE_TERMINATOR;
		endcase
	end

	// character feeder: one char at a time into the shifter
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			sif.load <= 1'b0;
			sif.chr <= '0;
			idx <= SLOT_HEAD;
			tail <= 1'b0;
			TEXT_READY <= 1'b0;
		end else begin
			sif.load <= 1'b0;
			TEXT_READY <= 1'b0;
			if (start_ok) begin
				idx <= SLOT_HEAD;
				tail <= 1'b0;
			end else if (state == ST_SEND && !err_evt) begin
				if (kind == KIND_TEXT && idx == SLOT_SECOND) begin
					// text body passes through with its own parity
					if (text_take) begin
						sif.load <= 1'b1;
						sif.chr <= TEXT_CHAR;
						if (TEXT_LAST) begin
							idx <= SLOT_LAST;
						end
					end else begin
						TEXT_READY <= free;
					end
				end else if (free && !tail) begin
					sif.load <= 1'b1;
					sif.chr <= cie_frame(next_char);
					idx <= idx + 2'h1;
					tail <= (idx == SLOT_LAST);
				end
			end
		end
	end

	// key lock: closed by a transfer, opened by enable or a failed transfer
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			keys_en <= 1'b1;
		end else if (start_ok) begin
			keys_en <= 1'b0;
		end else if (ENABLE_KEYS || err_evt) begin
			keys_en <= 1'b1;
		end
	end

	// error lamps, a new fault wins over a clear
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			INBOUND_FAULT_LAMP <= 1'b0;
			OUTBOUND_FAULT_LAMP <= 1'b0;
		end else begin
			if (err_evt) begin
				INBOUND_FAULT_LAMP <= 1'b1;
			end else if (LAMP_CLEAR) begin
				INBOUND_FAULT_LAMP <= 1'b0;
			end
			if (OUTBOUND_FAULT) begin
				OUTBOUND_FAULT_LAMP <= 1'b1;
			end else if (LAMP_CLEAR) begin
				OUTBOUND_FAULT_LAMP <= 1'b0;
			end
		end
	end

	// registered pin and status outputs
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			DEVICE_CLOCK <= 1'b0;
			INPUT_DATA <= 1'b0;
			KEYS_ENABLED <= 1'b0;
			BUSY <= 1'b0;
		end else begin
			DEVICE_CLOCK <= sif.clk_level && sif.active;
			INPUT_DATA <= sif.bit_out;
			KEYS_ENABLED <= keys_usable && (state == ST_IDLE);
			BUSY <= (state != ST_IDLE);
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	a_early_drop_lamp: assert property (line_fault |=> !AVAILABLE_LINE && INBOUND_FAULT_LAMP)
		else $error("early transfer end did not drop availability");
	a_own_parity_stop: assert property (par_fault |=> state == ST_ERROR && !AVAILABLE_LINE)
		else $error("bad text parity was not stopped");
	a_done_wait_limit: assert property (done_tmo |=> state == ST_ERROR ##1 !AVAILABLE_LINE)
		else $error("missing input done did not end transfer");
	a_idle_no_avail: assert property (state == ST_IDLE && sreq |=> !AVAILABLE_LINE)
		else $error("input started while send request true");
	a_request_blocked: assert property (state == ST_REQUEST && sreq |=> state == ST_REQUEST)
		else $error("grant taken while send request true");
	a_keys_locked: assert property (ok_evt |=> !keys_en [*2])
		else $error("keys reopened after a good transfer");
	a_standby_lock: assert property (STANDBY |=> !KEYS_ENABLED)
		else $error("keys enabled in standby");
	a_term_last: assert property (sif.load && tail |-> sif.chr == cie_frame(MESSAGE_TERMINATOR))
		else $error("last character is not the terminator");
	a_out_lamp: assert property (OUTBOUND_FAULT |=> OUTBOUND_FAULT_LAMP)
		else $error("outbound fault lamp not lit");
	a_clock_gated: assert property (!sif.active |=> !DEVICE_CLOCK)
		else $error("device clock ran with no character");

	c_good_transfer: cover property (ok_evt);
	c_parity_stop: cover property (par_fault);
	c_done_timeout: cover property (done_tmo);
	c_early_drop: cover property (line_fault);
endmodule

// *** test/cie_proc_model.sv ***
`timescale 1ns/1ps
// processor end: grants input, deserialises, checks parity, times out
module cie_proc_model import cie_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// lines from the console
	input wire logic dev_clk,
	input wire logic data_in,
	input wire logic avail,
	// lines to the console
	output logic xfer_active,
	output logic done,
	output logic send_req,
	// fault injection and adjustable timeout
	input wire logic bad_parity,
	input wire logic no_done,
	input wire logic early_done,
	input wire logic hold_send,
	input wire logic clear_flags,
	input wire logic [15:0] tmo_limit,
	// received characters and fault flags {parity, console, timeout}
	output logic [4*CHAR_W-1:0] rx_chars,
	output logic [3:0] rx_count,
	output logic [2:0] flags
);
	logic dclk_q; // last device clock level
	logic armed; // console released since last transfer
	logic [FRAME_W-1:0] shreg; // incoming bits, first at bit 0
	logic [2:0] nbit; // bit slot within the frame
	logic [15:0] tcnt; // age of the transfer in cycles
	logic term; // terminator taken, done due at its last clock fall

	// output request simply follows the bench
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			send_req <= 1'b0;
		end else begin
			send_req <= hold_send;
		end
	end

	// grant, receive, normal end and fault handling
	always_ff @(posedge clk or posedge rst) begin
		logic [FRAME_W-1:0] frame;
		if (rst) begin
			{dclk_q, armed, xfer_active, done, term} <= 5'h0;
			{shreg, nbit, tcnt, rx_chars, rx_count, flags} <= '0;
		end else begin
			frame = {data_in, shreg[FRAME_W-1:1]};
			dclk_q <= dev_clk;
			tcnt <= xfer_active ? tcnt + 16'h1 : 16'h0;
			// software clears the detailed flags
			if (clear_flags) begin
				flags <= 3'h0;
			end
			if (!xfer_active) begin
				nbit <= 3'h0;
				if (!avail) begin
					armed <= 1'b1;
				end
				// one console: flags never stop the grant
				if (avail && armed && !send_req) begin
					xfer_active <= 1'b1;
					armed <= 1'b0;
					rx_count <= 4'h0;
					rx_chars <= '0;
					term <= 1'b0;
				end
			end else if (done) begin
				// hold done until the console lets go
				if (!avail) begin
					xfer_active <= 1'b0;
					done <= 1'b0;
				end
			end else if (tcnt >= tmo_limit) begin
				xfer_active <= 1'b0;
				flags[0] <= 1'b1;
			end else if (!avail) begin
				xfer_active <= 1'b0;
				flags[1] <= 1'b1;
			end else if (early_done) begin
				done <= 1'b1;
				flags[1] <= 1'b1;
			end else if (term && !dev_clk && dclk_q) begin
				// done only after the last clock of the frame, not while it still sends
				done <= 1'b1;
				term <= 1'b0;
			end else if (dev_clk && !dclk_q) begin
				shreg <= frame;
				nbit <= (nbit == 3'h6) ? 3'h0 : nbit + 3'h1;
				if (nbit == 3'h6 && (!(^frame) || bad_parity)) begin
					xfer_active <= 1'b0;
					flags[2] <= 1'b1;
				end else if (nbit == 3'h6) begin
					if (rx_count < 4'h4) begin
						rx_chars[rx_count*CHAR_W +: CHAR_W] <= frame[CHAR_W-1:0];
					end
					rx_count <= rx_count + 4'h1;
					if (frame[CHAR_W-1:0] == MESSAGE_TERMINATOR && !no_done) begin
						term <= 1'b1;
					end
				end
			end
		end
	end
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
// console end against the processor model
module tb import cie_pkg::*; ();
	localparam int SIM_DONE_WAIT = 200; // short done wait
	localparam logic [14:0] EXP_FLAGS = 15'h2294; // per fault, 3 bits each
	logic CLOCK, RST, TRANSFER_ACTIVE_LINE, INPUT_DONE_LINE, SEND_REQUEST_LINE;
	logic AVAILABLE_LINE, DEVICE_CLOCK, INPUT_DATA, MSG_KEY, FUNC_KEY, LOGIC_KEY;
	logic [3:0] MSG_CODE;
	logic [CHAR_W-1:0] FUNC_CODE, LOGIC_CODE, OVERLAY_CODE;
	logic [1:0] TEXT_DISPLAY_PAGE;
	logic STANDBY, ENABLE_KEYS, OUTBOUND_FAULT, LAMP_CLEAR, TEXT_VALID, TEXT_LAST, TEXT_READY;
	logic [FRAME_W-1:0] TEXT_CHAR;
	logic KEYS_ENABLED, INBOUND_FAULT_LAMP, OUTBOUND_FAULT_LAMP, BUSY;
	logic bad_parity, no_done, early_done, hold_send, clear_flags;
	logic [15:0] tmo_limit;
	logic [4*CHAR_W-1:0] rx_chars;
	logic [3:0] rx_count;
	logic [2:0] flags;
	logic [5:0] pls; // one-hot pulse inputs
	int fail_count = 0;
	int num_checks = 0;

	assign {LAMP_CLEAR, OUTBOUND_FAULT, ENABLE_KEYS, LOGIC_KEY, FUNC_KEY, MSG_KEY} = pls;

	cie_console #(.DONE_WAIT_CYCLES(SIM_DONE_WAIT)) dut (
		.CLOCK(CLOCK), .RST(RST), .TRANSFER_ACTIVE_LINE(TRANSFER_ACTIVE_LINE),
		.INPUT_DONE_LINE(INPUT_DONE_LINE), .SEND_REQUEST_LINE(SEND_REQUEST_LINE),
		.AVAILABLE_LINE(AVAILABLE_LINE), .DEVICE_CLOCK(DEVICE_CLOCK), .INPUT_DATA(INPUT_DATA),
		.MSG_KEY(MSG_KEY), .MSG_CODE(MSG_CODE), .FUNC_KEY(FUNC_KEY), .FUNC_CODE(FUNC_CODE),
		.LOGIC_KEY(LOGIC_KEY), .LOGIC_CODE(LOGIC_CODE), .TEXT_DISPLAY_PAGE(TEXT_DISPLAY_PAGE),
		.OVERLAY_CODE(OVERLAY_CODE), .STANDBY(STANDBY), .ENABLE_KEYS(ENABLE_KEYS),
		.OUTBOUND_FAULT(OUTBOUND_FAULT), .LAMP_CLEAR(LAMP_CLEAR), .TEXT_VALID(TEXT_VALID),
		.TEXT_CHAR(TEXT_CHAR), .TEXT_LAST(TEXT_LAST), .TEXT_READY(TEXT_READY),
		.KEYS_ENABLED(KEYS_ENABLED), .INBOUND_FAULT_LAMP(INBOUND_FAULT_LAMP),
		.OUTBOUND_FAULT_LAMP(OUTBOUND_FAULT_LAMP), .BUSY(BUSY));

	cie_proc_model proc (
		.clk(CLOCK), .rst(RST), .dev_clk(DEVICE_CLOCK), .data_in(INPUT_DATA),
		.avail(AVAILABLE_LINE), .xfer_active(TRANSFER_ACTIVE_LINE), .done(INPUT_DONE_LINE),
		.send_req(SEND_REQUEST_LINE), .bad_parity(bad_parity), .no_done(no_done),
		.early_done(early_done), .hold_send(hold_send), .clear_flags(clear_flags),
		.tmo_limit(tmo_limit), .rx_chars(rx_chars), .rx_count(rx_count), .flags(flags));

	// compare one result and count it
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// counts, verdict and stop
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// one-cycle pulse: 0 msg, 1 func, 2 logic, 3 enable, 4 outbound, 5 clear
	task automatic pulse(input int k);
		@(posedge CLOCK);
		pls <= 6'h1 << k;
		@(posedge CLOCK);
		pls <= 6'h0;
		repeat (2) @(posedge CLOCK);
	endtask

	// offer a text character, hold it until taken
	task automatic text(input logic [5:0] c, input logic last, input logic bad);
		TEXT_CHAR <= {~^c ^ bad, c};
		TEXT_LAST <= last;
		TEXT_VALID <= 1'b1;
		for (int i = 0; i < 2000; i++) begin
			@(posedge CLOCK);
			if (TEXT_READY === 1'b1) break;
		end
		if (last) TEXT_VALID <= 1'b0;
	endtask

	// wait for a transfer to start and the console to settle idle
	task automatic wait_end();
		for (int i = 0; i < 50 && AVAILABLE_LINE !== 1'b1; i++) @(posedge CLOCK);
		for (int i = 0; i < 3000 && (BUSY !== 1'b0 || TRANSFER_ACTIVE_LINE !== 1'b0); i++) begin
			@(posedge CLOCK);
		end
		repeat (4) @(posedge CLOCK);
	endtask

	// expected four characters, first one in the low bits
	function automatic logic [23:0] exp_msg(input int k);
		case (k)
			0: return {MESSAGE_TERMINATOR, 6'h3a, 6'h21, 2'h0, MSG_CODE};
			1: return {MESSAGE_TERMINATOR, FUNC_CODE, ZERO_CHAR, 2'h1, CTRL_KEY_TYPE};
			default: return {MESSAGE_TERMINATOR, LOGIC_CODE, OVERLAY_CODE, 2'h2, LOGIC_KEY_TYPE};
		endcase
	endfunction

	// system clock
	initial begin
		CLOCK = 1'b0;
		forever #4 CLOCK = ~CLOCK;
	end

	// watchdog against a hang
	initial begin
		repeat (60000) @(posedge CLOCK);
		fail_count++;
		end_of_test();
	end

	// main sequence
	initial begin
		RST = 1'b1;
		pls = 6'h0;
		{bad_parity, no_done, early_done, hold_send, clear_flags, STANDBY} = 6'h0;
		{TEXT_VALID, TEXT_LAST, TEXT_CHAR, TEXT_DISPLAY_PAGE} = 11'h0;
		MSG_CODE = 4'h3;
		FUNC_CODE = 6'h05;
		LOGIC_CODE = 6'h2a;
		OVERLAY_CODE = 6'h11;
		tmo_limit = 16'h0fa0;
		repeat (2) @(posedge CLOCK);
		chk("reset outputs", 8'h0, {AVAILABLE_LINE, DEVICE_CLOCK, INPUT_DATA, TEXT_READY,
			KEYS_ENABLED, INBOUND_FAULT_LAMP, OUTBOUND_FAULT_LAMP, BUSY});
		RST <= 1'b0;
		repeat (4) @(posedge CLOCK);
		chk("keys after reset", 1'b1, KEYS_ENABLED);
		// message, function and logic keys; lock after success
		for (int k = 0; k < 3; k++) begin
			TEXT_DISPLAY_PAGE <= k[1:0];
			pulse(k);
			if (k == 0) begin
				text(6'h21, 1'b0, 1'b0);
				text(6'h3a, 1'b1, 1'b0);
			end
			wait_end();
			chk("message chars", exp_msg(k), rx_chars);
			chk("char count", 4'h4, rx_count);
			chk("keys locked", 1'b0, KEYS_ENABLED);
			pulse(1);
			repeat (8) @(posedge CLOCK);
			chk("locked press", 1'b0, AVAILABLE_LINE);
			pulse(3);
			chk("keys enabled", 1'b1, KEYS_ENABLED);
		end
		// faults: processor parity, no done, early done, timeout, bad text
		for (int e = 0; e < 5; e++) begin
			{bad_parity, no_done, early_done} <= 3'h4 >> e;
			tmo_limit <= (e == 3) ? 16'h012c : 16'h0fa0;
			pulse((e == 4) ? 0 : 1);
			if (e == 4) text(6'h15, 1'b1, 1'b1);
			wait_end();
			chk("inbound lamp", 1'b1, INBOUND_FAULT_LAMP);
			chk("fault flags", EXP_FLAGS[e*3 +: 3], flags);
			chk("keys after fault", 2'h1, {AVAILABLE_LINE, KEYS_ENABLED});
			{bad_parity, no_done, early_done} <= 3'h0;
			clear_flags <= 1'b1;
			pulse(5);
			clear_flags <= 1'b0;
			chk("lamp cleared", 1'b0, INBOUND_FAULT_LAMP);
		end
		// standby, then a held send request: keys shut, press ignored
		for (int s = 0; s < 2; s++) begin
			{STANDBY, hold_send} <= 2'h2 >> s;
			repeat (6) @(posedge CLOCK);
			chk("keys shut", 1'b0, KEYS_ENABLED);
			pulse(1);
			repeat (8) @(posedge CLOCK);
			chk("press refused", 1'b0, AVAILABLE_LINE);
			{STANDBY, hold_send} <= 2'h0;
			repeat (6) @(posedge CLOCK);
			chk("keys back", 1'b1, KEYS_ENABLED);
		end
		// outbound error lamp apart from the inbound one
		pulse(4);
		chk("lamps", 2'h2, {OUTBOUND_FAULT_LAMP, INBOUND_FAULT_LAMP});
		pulse(5);
		chk("lamps cleared", 2'h0, {OUTBOUND_FAULT_LAMP, INBOUND_FAULT_LAMP});
		end_of_test();
	end
endmodule
